// file: hw/paer_bank.sv
// design: error logging registers of a root port behind an apb slave
//
// How it works
// - pointer frozen until unmasked errors cleared, except for a higher severity overwrite
// - end-to-end crc bits read zero, read-only
// - five-bit pointer gives first error position
// - higher severity later error overwrites pointer
// - simultaneous errors load lowest bit position
// - logs and enables survive system reset
// - first error captures three dwords, four if four_dw set, if it saves header
// - new capture only after unmasked status cleared
// - header byte 0 in top lane
// - dwords 1..3 hold bytes 4..15 likewise
// - three-dword header leaves fourth dword untouched
// - bit 2 enables fatal interrupt
// - bit 1 enables nonfatal interrupt
// - bit 0 enables correctable interrupt
// - system error from messages separately disabled
// - received message sets first flag, logs requester
module paer_bank
  import paer_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power-up reset, clears sticky state
  input wire logic pwr_rstn,
  // error sources
  input wire paer_unc_s unc_in,
  input wire logic [PAER_UNC_W-1:0] unc_mask,
  input wire paer_msg_s msg_in,
  // outputs
  output logic err_irq,
  output logic sys_err,
  output logic irq
);

  // ************************************************
  // apb decode
  // ************************************************
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic rd_sel_caps = (paddr == PAER_OFF_CAPS);
  wire logic sel_hdr0 = (paddr == PAER_OFF_HDR0);
  wire logic sel_hdr1 = (paddr == PAER_OFF_HDR1);
  wire logic sel_hdr2 = (paddr == PAER_OFF_HDR2);
  wire logic sel_hdr3 = (paddr == PAER_OFF_HDR3);
  wire logic sel_enab = (paddr == PAER_OFF_ENAB);
  wire logic sel_flag = (paddr == PAER_OFF_FLAG);
  wire logic sel_uncs = (paddr == PAER_OFF_UNCS);
  wire logic sel_ctrl = (paddr == PAER_OFF_CTRL);
  wire logic sel_ists = (paddr == PAER_OFF_ISTS);
  wire logic sel_imsk = (paddr == PAER_OFF_IMSK);
  wire logic mapped = rd_sel_caps | sel_hdr0 | sel_hdr1 | sel_hdr2 | sel_hdr3 | sel_enab
    | sel_flag | sel_uncs | sel_ctrl | sel_ists | sel_imsk;

  // ************************************************
  // state
  // ************************************************
  logic [PAER_PTR_W-1:0] ptr_reg, ptr_next;
  logic [PAER_UNC_W-1:0] uncs_reg, uncs_next;
  logic [PAER_UNC_W-1:0] fsev_reg, fsev_next;
  logic [31:0] hdr_reg [PAER_HDR_WORDS];
  paer_log_e log_reg, log_next;
  logic [PAER_ENAB_W-1:0] enab_reg;
  logic [PAER_FLAG_W-1:0] flag_reg, flag_next;
  logic [15:0] srcid_reg;
  logic ctrl_reg;
  logic [PAER_ISTS_W-1:0] ists_reg, imsk_reg;
  logic [PAER_ISTS_W-1:0] ists_set;

  // ************************************************
  // first error pointer and header capture
  // ************************************************
  wire logic [PAER_UNC_W-1:0] new_err = unc_in.bits & ~unc_mask;
  wire logic [PAER_UNC_W-1:0] sev_err = new_err & unc_in.severity;
  wire logic unc_clr = wr & sel_uncs;
  wire logic [PAER_UNC_W-1:0] uncs_kept = unc_clr ? (uncs_reg & ~pwdata) : uncs_reg;
  wire logic all_clear = ((uncs_kept & ~unc_mask) == PAER_ZERO32);
  wire logic any_new = |new_err;
  wire logic log_free = (log_reg == PAER_LOG_ARMED);
  wire logic higher_sev = (|sev_err) & ~(|fsev_reg);

  // lowest set bit among a group
  function automatic logic [PAER_PTR_W-1:0] lowest(input logic [PAER_UNC_W-1:0] v);
    logic [PAER_PTR_W-1:0] r;
    r = PAER_PTR_RST;
    for (int i = PAER_UNC_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PAER_PTR_W'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    ptr_next = ptr_reg;
    fsev_next = fsev_reg;
    log_next = log_reg;
    uncs_next = uncs_kept | new_err;
    if (log_free && any_new) begin
      ptr_next = lowest(new_err);
      fsev_next = sev_err;
      log_next = PAER_LOG_HELD;
    end else if (!log_free && higher_sev) begin
      ptr_next = lowest(sev_err);
      fsev_next = sev_err;
    end else if (!log_free && all_clear && !any_new) begin
      log_next = PAER_LOG_ARMED;
      fsev_next = PAER_ZERO32;
    end
    case (log_reg)
      PAER_LOG_ARMED: ;
      PAER_LOG_HELD: ;
      default: log_next = PAER_LOG_ARMED;
    endcase
  end

  wire logic cap = log_free & any_new & unc_in.save_hdr;

  // byte 0 goes to the top lane of dword 0
  genvar g;
  generate
    for (g = 0; g < PAER_HDR_WORDS; g++) begin : g_hdr
      wire logic we = cap & ((g < PAER_HDR_WORDS - 1) | unc_in.four_dw);
      always_ff @(posedge pclk or negedge pwr_rstn) begin
        if (!pwr_rstn) begin
          hdr_reg[g] <= PAER_ZERO32;
        end else if (we) begin
          hdr_reg[g] <= unc_in.hdr[PAER_BYTES*8-1-32*g -: 32];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge pwr_rstn) begin
    if (!pwr_rstn) begin
      ptr_reg <= PAER_PTR_RST;
      uncs_reg <= PAER_ZERO32;
      fsev_reg <= PAER_ZERO32;
      log_reg <= PAER_LOG_ARMED;
    end else begin
      ptr_reg <= ptr_next;
      uncs_reg <= uncs_next;
      fsev_reg <= fsev_next;
      log_reg <= log_next;
    end
  end

  // ************************************************
  // received message flags
  // ************************************************
  wire logic msg_unc = msg_in.fatal | msg_in.nonfatal;
  wire logic flag_clr = wr & sel_flag;
  wire logic [PAER_FLAG_W-1:0] flag_kept = flag_clr ? (flag_reg & ~pwdata[PAER_FLAG_W-1:0]) : flag_reg;

  always_comb begin
    flag_next = flag_kept;
    if (msg_in.fatal) begin
      flag_next[PAER_FLAG_FATAL] = 1'b1;
    end
    if (msg_in.nonfatal) begin
      flag_next[PAER_FLAG_NONFATAL] = 1'b1;
    end
    if (msg_unc) begin
      if (flag_reg[PAER_FLAG_FIRST_UNC]) begin
        flag_next[PAER_FLAG_MULT_UNC] = 1'b1;
      end else begin
        flag_next[PAER_FLAG_FIRST_UNC] = 1'b1;
        flag_next[PAER_FLAG_FIRST_FATAL] = msg_in.fatal;
      end
    end
    if (msg_in.correctable) begin
      if (flag_reg[PAER_FLAG_FIRST_COR]) begin
        flag_next[PAER_FLAG_MULT_COR] = 1'b1;
      end else begin
        flag_next[PAER_FLAG_FIRST_COR] = 1'b1;
      end
    end
  end

  wire logic first_new = (msg_unc & ~flag_reg[PAER_FLAG_FIRST_UNC])
    | (msg_in.correctable & ~flag_reg[PAER_FLAG_FIRST_COR]);

  always_ff @(posedge pclk or negedge pwr_rstn) begin
    if (!pwr_rstn) begin
      flag_reg <= '0;
      srcid_reg <= '0;
      enab_reg <= '0;
      ctrl_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      if (first_new) begin
        srcid_reg <= msg_in.requester;
      end
      if (wr && sel_enab) begin
        enab_reg <= pwdata[PAER_ENAB_W-1:0];
      end
      if (wr && sel_ctrl) begin
        ctrl_reg <= pwdata[PAER_CTRL_SERR_DIS];
      end
    end
  end

  // ************************************************
  // error interrupt and system error
  // ************************************************
  wire logic fat_req = enab_reg[PAER_ENAB_FATAL] & flag_reg[PAER_FLAG_FATAL];
  wire logic nf_req = enab_reg[PAER_ENAB_NONFATAL] & flag_reg[PAER_FLAG_NONFATAL];
  wire logic cor_req = enab_reg[PAER_ENAB_CORR] & flag_reg[PAER_FLAG_FIRST_COR];
  wire logic any_msg_flag = flag_reg[PAER_FLAG_FATAL] | flag_reg[PAER_FLAG_NONFATAL]
    | flag_reg[PAER_FLAG_FIRST_COR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_irq <= 1'b0;
      sys_err <= 1'b0;
    end else begin
      err_irq <= fat_req | nf_req | cor_req;
      sys_err <= any_msg_flag & ~ctrl_reg;
    end
  end

  // ************************************************
  // block interrupt status and mask
  // ************************************************
  assign ists_set = {cap, msg_in.fatal, msg_in.nonfatal, msg_in.correctable};
  wire logic ists_clr = wr & sel_ists;
  wire logic [PAER_ISTS_W-1:0] ists_kept = ists_clr ? (ists_reg & ~pwdata[PAER_ISTS_W-1:0]) : ists_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_reg <= '0;
      imsk_reg <= '0;
    end else begin
      ists_reg <= ists_kept | ists_set;
      if (wr && sel_imsk) begin
        imsk_reg <= pwdata[PAER_ISTS_W-1:0];
      end
    end
  end

  assign irq = |(ists_reg & imsk_reg);

  // ************************************************
  // read mux
  // ************************************************
  logic [31:0] rdata;
  always_comb begin
    rdata = PAER_ZERO32;
    if (rd_sel_caps) begin
      rdata = {27'h0000000, ptr_reg};
    end else if (sel_hdr0) begin
      rdata = hdr_reg[0];
    end else if (sel_hdr1) begin
      rdata = hdr_reg[1];
    end else if (sel_hdr2) begin
      rdata = hdr_reg[2];
    end else if (sel_hdr3) begin
      rdata = hdr_reg[3];
    end else if (sel_enab) begin
      rdata = {29'h00000000, enab_reg};
    end else if (sel_flag) begin
      rdata = {9'h000, srcid_reg, 7'h00} | {25'h0000000, flag_reg};
    end else if (sel_uncs) begin
      rdata = uncs_reg;
    end else if (sel_ctrl) begin
      rdata = {31'h00000000, ctrl_reg};
    end else if (sel_ists) begin
      rdata = {28'h0000000, ists_reg};
    end else if (sel_imsk) begin
      rdata = {28'h0000000, imsk_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PAER_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata;
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

endmodule

// file: include/paer_pkg.sv
// package: register map, field layout and types of the error logging bank
package paer_pkg;

  // ************************************************
  // register byte offsets
  // ************************************************
  localparam logic [11:0] PAER_OFF_CAPS = 12'h118;
  localparam logic [11:0] PAER_OFF_HDR0 = 12'h11C;
  localparam logic [11:0] PAER_OFF_HDR1 = 12'h120;
  localparam logic [11:0] PAER_OFF_HDR2 = 12'h124;
  localparam logic [11:0] PAER_OFF_HDR3 = 12'h128;
  localparam logic [11:0] PAER_OFF_ENAB = 12'h12C;
  localparam logic [11:0] PAER_OFF_FLAG = 12'h130;
  localparam logic [11:0] PAER_OFF_UNCS = 12'h140;
  localparam logic [11:0] PAER_OFF_CTRL = 12'h144;
  localparam logic [11:0] PAER_OFF_ISTS = 12'h148;
  localparam logic [11:0] PAER_OFF_IMSK = 12'h14C;

  // ************************************************
  // field layout and reset values
  // ************************************************
  localparam int PAER_PTR_W = 5;
  localparam int PAER_UNC_W = 32;
  localparam int PAER_ENAB_W = 3;
  localparam int PAER_FLAG_W = 7;
  localparam int PAER_ISTS_W = 4;
  localparam int PAER_HDR_WORDS = 4;
  localparam int PAER_BYTES = 16;
  localparam int PAER_ENAB_FATAL = 2;
  localparam int PAER_ENAB_NONFATAL = 1;
  localparam int PAER_ENAB_CORR = 0;
  localparam int PAER_FLAG_FATAL = 6;
  localparam int PAER_FLAG_NONFATAL = 5;
  localparam int PAER_FLAG_FIRST_FATAL = 4;
  localparam int PAER_FLAG_MULT_UNC = 3;
  localparam int PAER_FLAG_FIRST_UNC = 2;
  localparam int PAER_FLAG_MULT_COR = 1;
  localparam int PAER_FLAG_FIRST_COR = 0;
  localparam int PAER_CTRL_SERR_DIS = 0;
  localparam int PAER_ISTS_HDR = 3;
  localparam logic [31:0] PAER_ZERO32 = 32'h0000_0000;
  localparam logic [PAER_PTR_W-1:0] PAER_PTR_RST = 5'h00;
  localparam logic [31:0] PAER_SLVERR_NONE = 32'h0000_0000;

  // ************************************************
  // types
  // ************************************************
  typedef logic [PAER_BYTES*8-1:0] paer_hdr_t;

  // one uncorrectable error report from the link logic
  typedef struct packed {
    logic [PAER_UNC_W-1:0] bits;
    logic [PAER_UNC_W-1:0] severity;
    logic save_hdr;
    logic four_dw;
    paer_hdr_t hdr;
  } paer_unc_s;

  // one received error message
  typedef struct packed {
    logic correctable;
    logic nonfatal;
    logic fatal;
    logic [15:0] requester;
  } paer_msg_s;

  typedef enum logic [1:0] {
    PAER_LOG_ARMED = 2'b00,
    PAER_LOG_HELD = 2'b01
  } paer_log_e;

endpackage

// file: test/paer_bank_assertions.sv
// checker: port-level properties of the error logging bank
module paer_bank_assertions
  import paer_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // power-up reset and error sources
  input wire logic pwr_rstn,
  input wire paer_unc_s unc_in,
  input wire logic [PAER_UNC_W-1:0] unc_mask,
  input wire paer_msg_s msg_in,
  // outputs
  input wire logic err_irq,
  input wire logic sys_err,
  input wire logic irq
);
  // ****************
  // shadow registers
  // ****************
  logic [2:0] en_sh;
  logic dis_sh;
  logic [3:0] msk_sh;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  // enables and control are sticky: only power-up reset clears them
  always_ff @(posedge pclk or negedge pwr_rstn) begin
    if (!pwr_rstn) begin
      en_sh <= 3'h0;
      dis_sh <= 1'b0;
    end else begin
      if (wr && paddr == PAER_OFF_ENAB) en_sh <= pwdata[2:0];
      if (wr && paddr == PAER_OFF_CTRL) dis_sh <= pwdata[0];
    end
  end
  // interrupt mask follows system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) msk_sh <= 4'h0;
    else if (wr && paddr == PAER_OFF_IMSK) msk_sh <= pwdata[3:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_caps_zero: assert property (
    rd && paddr == PAER_OFF_CAPS |-> prdata[31:5] == 27'h0) else $error("caps upper bits set");
  a_enab_sticky: assert property (
    rd && paddr == PAER_OFF_ENAB |-> prdata == {29'h0, en_sh}) else $error("enable readback differs");
  a_fatal_irq: assert property (
    msg_in.fatal && en_sh[2] |-> ##[1:3] err_irq) else $error("fatal message gave no interrupt");
  a_nonfatal_irq: assert property (
    msg_in.nonfatal && en_sh[1] |=> ##[0:2] err_irq) else $error("nonfatal message gave no interrupt");
  a_corr_irq: assert property (
    msg_in.correctable && en_sh[0] |-> ##[1:3] err_irq) else $error("correctable message gave no interrupt");
  a_irq_needs_en: assert property (
    en_sh == 3'h0 && $past(en_sh) == 3'h0 |-> !err_irq) else $error("interrupt with all enables off");
  a_sys_err_off: assert property (
    dis_sh && $past(dis_sh) |-> !sys_err) else $error("system error while disabled");
  a_irq_masked: assert property (
    msk_sh == 4'h0 |-> !irq) else $error("irq with mask clear");
endmodule
bind paer_bank paer_bank_assertions paer_bank_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .pwr_rstn, .unc_in, .unc_mask, .msg_in, .err_irq, .sys_err, .irq);

// file: test/paer_link_model.sv
// model: downstream devices raising uncorrectable errors and error messages
module paer_link_model
  import paer_pkg::*;
(
  // clock
  input wire logic pclk,
  // reports toward the bank
  output paer_unc_s unc_in,
  output paer_msg_s msg_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    unc_in = '0;
    msg_in = '0;
  end
  // one-cycle report, header bytes base upward, then bits and flags cleared, severity and header inverted
  task automatic send_unc(input logic [31:0] bits, input logic [31:0] sev, input logic save,
                          input logic four, input logic [7:0] base);
    int i;
    paer_hdr_t h;
    for (i = 0; i < PAER_BYTES; i++) h[127-8*i -: 8] = base + 8'(i);
    @(posedge pclk);
    unc_in <= '{bits, sev, save, four, h};
    @(posedge pclk);
    unc_in <= '{32'h0, ~sev, 1'b0, 1'b0, ~h};
  endtask
  // one-cycle message, cls bit0 correctable, bit1 nonfatal, bit2 fatal
  task automatic send_msg(input logic [2:0] cls, input logic [15:0] req);
    @(posedge pclk);
    msg_in <= '{cls[0], cls[1], cls[2], req};
    @(posedge pclk);
    msg_in <= '{1'b0, 1'b0, 1'b0, ~req};
  endtask
endmodule

// file: test/tb_paer_bank.sv
// testbench: register, capture and interrupt scenarios of the error logging bank
module tb_paer_bank
  import paer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, pwr_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_irq, sys_err, irq;
  logic [PAER_UNC_W-1:0] unc_mask = '0;
  paer_unc_s unc_in;
  paer_msg_s msg_in;
  int bad_count = 0, n_tests = 0;
  initial forever #50 pclk = ~pclk;
  paer_bank paer_bank_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pwr_rstn, .unc_in, .unc_mask, .msg_in, .err_irq, .sys_err, .irq);
  paer_link_model paer_link_model_inst (.pclk, .unc_in, .msg_in);
  // ****************
  // helpers
  // ****************
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      bad_count++;
      report_and_stop();
    end else begin
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 8 && err_irq !== v; n++) @(posedge pclk);
    chk("err_irq", {31'h0, v}, {31'h0, err_irq});
    if (err_irq !== v) report_and_stop();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rchk("caps", PAER_OFF_CAPS, 32'h0);
    rchk("enab", PAER_OFF_ENAB, 32'h0);
    apb(1'b1, PAER_OFF_CAPS, 32'hFFFF_FFFF);
    apb(1'b1, PAER_OFF_HDR3, 32'hFFFF_FFFF);
    rchk("caps", PAER_OFF_CAPS, 32'h0);
    rchk("hdr3", PAER_OFF_HDR3, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("slverr", 32'h1, {31'h0, slv});
  endtask
  task automatic t_capture();
    int k;
    paer_link_model_inst.send_unc(32'h8, 32'h0, 1'b1, 1'b1, 8'h00);
    for (k = 0; k < 4; k++) rchk("hdr", PAER_OFF_HDR0 + 12'(4*k), 32'h00010203 + 32'(k) * 32'h04040404);
    rchk("ptr", PAER_OFF_CAPS, 32'h3);
    paer_link_model_inst.send_unc(32'h2, 32'h0, 1'b1, 1'b1, 8'h40);
    rchk("hdr0", PAER_OFF_HDR0, 32'h00010203);
    rchk("ptr", PAER_OFF_CAPS, 32'h3);
    paer_link_model_inst.send_unc(32'h20, 32'h20, 1'b0, 1'b0, 8'h80);
    rchk("ptr", PAER_OFF_CAPS, 32'h5);
    apb(1'b1, PAER_OFF_IMSK, 32'h8);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, PAER_OFF_ISTS, 32'h8);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, PAER_OFF_UNCS, 32'hFFFF_FFFF);
    rchk("uncs", PAER_OFF_UNCS, 32'h0);
    paer_link_model_inst.send_unc(32'h1200, 32'h0, 1'b1, 1'b0, 8'h10);
    rchk("ptr", PAER_OFF_CAPS, 32'h9);
    for (k = 0; k < 3; k++) rchk("hdr", PAER_OFF_HDR0 + 12'(4*k), 32'h10111213 + 32'(k) * 32'h04040404);
    rchk("hdr3", PAER_OFF_HDR3, 32'h0C0D0E0F);
    unc_mask <= 32'h0000_1000;
    paer_link_model_inst.send_unc(32'h1000, 32'h0, 1'b1, 1'b1, 8'h60);
    apb(1'b1, PAER_OFF_UNCS, 32'h0000_0200);
    paer_link_model_inst.send_unc(32'h4, 32'h0, 1'b0, 1'b0, 8'h70);
    rchk("ptr", PAER_OFF_CAPS, 32'h2);
    rchk("hdr1", PAER_OFF_HDR1, 32'h14151617);
    unc_mask <= '0;
  endtask
  task automatic t_msg();
    int i;
    logic [6:0] fl [3] = '{7'h01, 7'h24, 7'h54};
    for (i = 0; i < 3; i++) begin
      apb(1'b1, PAER_OFF_ENAB, 32'(1 << i));
      paer_link_model_inst.send_msg(3'(1 << i), 16'hABCD);
      wait_irq(1'b1);
      chk("sys_err", 32'h1, {31'h0, sys_err});
      rchk("flags", PAER_OFF_FLAG, {9'h0, 16'hABCD, fl[i]});
      apb(1'b1, PAER_OFF_FLAG, 32'h7F);
      wait_irq(1'b0);
    end
    apb(1'b1, PAER_OFF_ENAB, 32'h0);
    paer_link_model_inst.send_msg(3'h4, 16'h1234);
    repeat (3) @(posedge pclk);
    chk("err_irq", 32'h0, {31'h0, err_irq});
    apb(1'b1, PAER_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("sys_err", 32'h0, {31'h0, sys_err});
    apb(1'b1, PAER_OFF_ENAB, 32'h4);
    wait_irq(1'b1);
  endtask
  task automatic t_sticky();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ptr", PAER_OFF_CAPS, 32'h2);
    rchk("hdr1", PAER_OFF_HDR1, 32'h14151617);
    rchk("enab", PAER_OFF_ENAB, 32'h4);
    @(posedge pclk);
    presetn <= 1'b0;
    pwr_rstn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pwr_rstn <= 1'b1;
    rchk("ptr", PAER_OFF_CAPS, 32'h0);
    rchk("hdr1", PAER_OFF_HDR1, 32'h0);
    rchk("enab", PAER_OFF_ENAB, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    pwr_rstn <= 1'b1;
    t_regs();
    t_capture();
    t_msg();
    t_sticky();
    report_and_stop();
  end
endmodule
